// ---- data_area_pkg.sv ----
// ****************************************************************
// shared constants and types of the data-area address map
// ****************************************************************
package data_area_pkg;

   // ****************************************************************
   // bus widths
   // ****************************************************************
   localparam int ADDR_W = 16;                              // data-area address width
   localparam int DATA_W = 8;                               // data width
   localparam int BOOT_ADDR_W = 12;                         // boot rom address width

   // ****************************************************************
   // register-window bounds
   // ****************************************************************
   localparam logic [15:0] REGWIN_LOW_FIRST  = 16'h0000;    // low window start
   localparam logic [15:0] REGWIN_LOW_LAST   = 16'h003f;    // low window end
   localparam logic [15:0] REGWIN_HIGH_FIRST = 16'h0f00;    // high window start
   localparam logic [15:0] REGWIN_HIGH_LAST  = 16'h0fff;    // high window end
   localparam logic [15:0] REGWIN_MID_FIRST  = 16'h0e40;    // mid window start
   localparam logic [15:0] REGWIN_MID_LAST   = 16'h0eff;    // mid window end

   // ****************************************************************
   // memory bounds
   // ****************************************************************
   localparam logic [15:0] RAM_FIRST     = 16'h0040;        // ram start
   localparam logic [15:0] RAM_LAST      = 16'h083f;        // ram end
   localparam logic [15:0] BOOTROM_FIRST = 16'h1000;        // boot rom window start
   localparam logic [15:0] BOOTROM_LAST  = 16'h17ff;        // boot rom window end
   localparam logic [15:0] FLASH_FIRST   = 16'h8000;        // flash start
   localparam logic [15:0] FLASH_LAST    = 16'hffff;        // flash end
   localparam int          BOOT_MAP_BITS = 11;              // 2 kbyte reachable outside serial mode

   // ****************************************************************
   // local registers
   // ****************************************************************
   localparam logic [15:0] FLASH_MAP_STAGING_ADDR = 16'h0fd0;   // staging register
   localparam logic [15:0] FLASH_MAP_COMMIT_ADDR  = 16'h0fd1;   // commit register
   localparam logic [15:0] FLASH_MAP_MONITOR_ADDR = 16'h0fd2;   // active monitor
   localparam logic [7:0]  FLASH_MAP_RESET        = 8'h40;      // staging and active reset
   localparam int          BOOTROM_MAP_ENABLE_BIT = 4;          // map-enable position
   localparam logic [7:0]  COMMIT_CODE            = 8'hd5;      // only legal commit value
   localparam logic [7:0]  UNMAPPED_READ          = 8'hff;      // value of unmapped reads
   localparam logic [7:0]  WRITE_ONLY_READ        = 8'h00;      // read of write-only register

   // ****************************************************************
   // types
   // ****************************************************************
   typedef enum logic [2:0] {
      REG_NONE,
      REG_REGWIN_LOW,
      REG_REGWIN_HIGH,
      REG_REGWIN_MID,
      REG_RAM,
      REG_BOOTROM,
      REG_FLASH
   } region_t;

   typedef enum logic [1:0] {
      S_IDLE,
      S_ISSUE,
      S_WAIT,
      S_ACK
   } bus_state_t;

   // inclusive range test
   function automatic logic in_range(input logic [15:0] a,
                                     input logic [15:0] lo,
                                     input logic [15:0] hi);
      return (a >= lo) && (a <= hi);
   endfunction

endpackage

// ---- region_decode.sv ----
// ****************************************************************
// address to region decoder, used for data and code space
// ****************************************************************
module region_decode
   import data_area_pkg::*;
(
   // address in
   input  wire logic [15:0]            addr,
   // active boot rom map enable
   input  wire logic                   boot_mapped,
   // decoded region
   output data_area_pkg::region_t      region
);

   // ****************************************************************
   // priority decode
   // ****************************************************************
   always_comb begin
      // windows do not overlap, so order only matters for clarity
      if (in_range(addr, REGWIN_LOW_FIRST, REGWIN_LOW_LAST)) begin
         region = REG_REGWIN_LOW;
      end else if (in_range(addr, REGWIN_MID_FIRST, REGWIN_MID_LAST)) begin
         region = REG_REGWIN_MID;
      end else if (in_range(addr, REGWIN_HIGH_FIRST, REGWIN_HIGH_LAST)) begin
         region = REG_REGWIN_HIGH;
      end else if (in_range(addr, RAM_FIRST, RAM_LAST)) begin
         region = REG_RAM;
      end else if (boot_mapped && in_range(addr, BOOTROM_FIRST, BOOTROM_LAST)) begin
         region = REG_BOOTROM;
      end else if (in_range(addr, FLASH_FIRST, FLASH_LAST)) begin
         region = REG_FLASH;
      end else begin
         region = REG_NONE;
      end
   end

endmodule

// ---- data_area_map.sv ----
// Functional notes
// - three register windows decoded after reset
// - 0x0040 to 0x083f goes to ram
// - boot rom unmapped after reset
// - map enable maps boot rom, code and data
// - unmapped boot rom window reads 0xff
// - only low 2 kbyte outside serial mode
// - map enable is staging bit 4, reset 0
// - staging and active registers double-buffer mapping
// - writing 0xd5 to commit copies staging
// - monitor location reads active register
// - 0x8000 to 0xffff goes to flash
module data_area_map
   import data_area_pkg::*;
(
   // clock and reset
   input  wire logic                   CLK,
   input  wire logic                   RST,
   // wishbone slave from the processor data bus
   input  wire logic                   CYC_I,
   input  wire logic                   STB_I,
   input  wire logic                   WE_I,
   input  wire logic [15:0]            ADR_I,
   input  wire logic [7:0]             DAT_I,
   input  wire logic [0:0]             SEL_I,
   output logic      [7:0]             DAT_O,
   output logic                        ACK_O,
   // code-space fetch address and boot rom hit
   input  wire logic [15:0]            CODE_ADDR,
   output logic                        CODE_BOOTROM_HIT,
   // serial programming mode and upper boot rom bank
   input  wire logic                   SERIAL_PROG_MODE,
   input  wire logic                   SERIAL_BANK_SEL,
   // common target request
   output logic      [15:0]            TGT_ADDR,
   output logic      [7:0]             TGT_WDATA,
   output logic                        TGT_WE,
   // target selects
   output logic                        SEL_REGWIN_LOW,
   output logic                        SEL_REGWIN_HIGH,
   output logic                        SEL_REGWIN_MID,
   output logic                        SEL_RAM,
   output logic                        SEL_BOOTROM,
   output logic                        SEL_FLASH,
   output logic      [11:0]            BOOTROM_ADDR,
   // target read data
   input  wire logic [7:0]             RDATA_REGWIN,
   input  wire logic [7:0]             RDATA_RAM,
   input  wire logic [7:0]             RDATA_BOOTROM,
   input  wire logic [7:0]             RDATA_FLASH
);

   // ****************************************************************
   // state and registers
   // ****************************************************************
   bus_state_t       state_reg;                             // bus sequencer
   bus_state_t       state_next;                            // its next value
   logic [7:0]       staging_reg;                           // flash map staging
   logic [7:0]       active_reg;                            // flash map active
   logic [15:0]      addr_reg;                              // captured address
   logic [7:0]       wdata_reg;                             // captured write data
   logic             we_reg;                                // captured direction
   region_t          region_reg;                            // captured region
   logic             local_reg;                             // captured local-register hit
   logic             tgt_stb_reg;                           // one-cycle target strobe
   logic [7:0]       dat_o_reg;                             // read data to the bus
   logic             ack_reg;                               // bus acknowledge
   logic             bank_reg;                              // captured boot bank

   // ****************************************************************
   // decode wires
   // ****************************************************************
   wire logic        boot_mapped;                           // active map enable
   wire logic        req;                                   // valid bus request
   wire logic        wr_ok;                                 // write with lane enabled
   wire logic        hit_staging;                           // staging address
   wire logic        hit_commit;                            // commit address
   wire logic        hit_monitor;                           // monitor address
   wire logic        hit_local;                             // any local register
   region_t          data_region;                           // data-space region
   region_t          code_region;                           // code-space region
   wire logic        commit_now;                            // commit write this cycle
   wire logic        staging_wr;                            // staging write this cycle
   logic [7:0]       local_rdata;                           // local register read
   logic [7:0]       tgt_rdata;                             // forwarded read

   // active register alone steers decoding
   assign boot_mapped = active_reg[BOOTROM_MAP_ENABLE_BIT];
   assign req         = CYC_I && STB_I;
   assign wr_ok       = WE_I && SEL_I[0];
   assign hit_staging = (ADR_I == FLASH_MAP_STAGING_ADDR);
   assign hit_commit  = (ADR_I == FLASH_MAP_COMMIT_ADDR);
   assign hit_monitor = (ADR_I == FLASH_MAP_MONITOR_ADDR);
   assign hit_local   = hit_staging || hit_commit || hit_monitor;

   // ****************************************************************
   // region decoders for data and code space
   // ****************************************************************
   region_decode data_dec (
      .addr        (ADR_I),
      .boot_mapped (boot_mapped),
      .region      (data_region)
   );

   region_decode code_dec (
      .addr        (CODE_ADDR),
      .boot_mapped (boot_mapped),
      .region      (code_region)
   );

   // code fetches see the boot rom only while mapped
   assign CODE_BOOTROM_HIT = (code_region == REG_BOOTROM);

   // ****************************************************************
   // register writes, applied in the issue cycle
   // ****************************************************************
   assign staging_wr = (state_reg == S_ISSUE) && local_reg && we_reg
                       && (addr_reg == FLASH_MAP_STAGING_ADDR);
   // any other value written to commit is ignored
   assign commit_now = (state_reg == S_ISSUE) && local_reg && we_reg
                       && (addr_reg == FLASH_MAP_COMMIT_ADDR)
                       && (wdata_reg == COMMIT_CODE);

   // ****************************************************************
   // local read mux
   // ****************************************************************
   always_comb begin
      if (addr_reg == FLASH_MAP_STAGING_ADDR) begin
         local_rdata = staging_reg;
      end else if (addr_reg == FLASH_MAP_MONITOR_ADDR) begin
         local_rdata = active_reg;
      end else begin
         local_rdata = WRITE_ONLY_READ;                     // commit is write-only
      end
   end

   // ****************************************************************
   // forwarded read mux
   // ****************************************************************
   always_comb begin
      unique case (region_reg)
         REG_REGWIN_LOW,
         REG_REGWIN_HIGH,
         REG_REGWIN_MID: tgt_rdata = RDATA_REGWIN;
         REG_RAM:        tgt_rdata = RDATA_RAM;
         REG_BOOTROM:    tgt_rdata = RDATA_BOOTROM;
         REG_FLASH:      tgt_rdata = RDATA_FLASH;
         REG_NONE:       tgt_rdata = UNMAPPED_READ;
         // the eighth code of the region field is never produced
         default:        tgt_rdata = UNMAPPED_READ;
      endcase
   end

   // ****************************************************************
   // bus sequencer next state
   // ****************************************************************
   always_comb begin
      unique case (state_reg)
         S_IDLE:  state_next = req ? S_ISSUE : S_IDLE;     // take request
         S_ISSUE: state_next = S_WAIT;                      // target sees strobe
         S_WAIT:  state_next = S_ACK;                       // data captured
         S_ACK:   state_next = S_IDLE;                      // ack shown one cycle
      endcase
   end

   // ****************************************************************
   // sequencer and request capture
   // ****************************************************************
   always_ff @(posedge CLK) begin
      if (RST) begin
         state_reg   <= S_IDLE;
         addr_reg    <= 16'h0000;
         wdata_reg   <= 8'h00;
         we_reg      <= 1'b0;
         region_reg  <= REG_NONE;
         local_reg   <= 1'b0;
         bank_reg    <= 1'b0;
      end else begin
         state_reg <= state_next;
         // capture the request once, in idle
         if (state_reg == S_IDLE && req) begin
            addr_reg   <= ADR_I;
            wdata_reg  <= DAT_I;
            we_reg     <= wr_ok;
            region_reg <= data_region;
            local_reg  <= hit_local;
            bank_reg   <= SERIAL_PROG_MODE && SERIAL_BANK_SEL;
         end
      end
   end

   // ****************************************************************
   // target strobe, read data and acknowledge
   // ****************************************************************
   always_ff @(posedge CLK) begin
      if (RST) begin
         tgt_stb_reg <= 1'b0;
         dat_o_reg   <= 8'h00;
         ack_reg     <= 1'b0;
      end else begin
         // one-cycle strobe in the issue cycle, local hits stay inside
         tgt_stb_reg <= (state_reg == S_IDLE) && req && !hit_local
                        && (data_region != REG_NONE);
         ack_reg     <= (state_reg == S_WAIT);
         if (state_reg == S_WAIT) begin
            dat_o_reg <= we_reg ? 8'h00 : (local_reg ? local_rdata : tgt_rdata);
         end
      end
   end

   // ****************************************************************
   // flash map staging and active registers
   // ****************************************************************
   always_ff @(posedge CLK) begin
      if (RST) begin
         staging_reg <= FLASH_MAP_RESET;
         active_reg  <= FLASH_MAP_RESET;
      end else begin
         if (staging_wr) begin
            staging_reg <= wdata_reg;
         end
         if (commit_now) begin
            active_reg <= staging_reg;
         end
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   assign DAT_O     = dat_o_reg;
   assign ACK_O     = ack_reg;
   assign TGT_ADDR  = addr_reg;
   assign TGT_WDATA = wdata_reg;
   assign TGT_WE    = tgt_stb_reg && we_reg;

   assign SEL_REGWIN_LOW  = tgt_stb_reg && (region_reg == REG_REGWIN_LOW);
   assign SEL_REGWIN_HIGH = tgt_stb_reg && (region_reg == REG_REGWIN_HIGH);
   assign SEL_REGWIN_MID  = tgt_stb_reg && (region_reg == REG_REGWIN_MID);
   assign SEL_RAM         = tgt_stb_reg && (region_reg == REG_RAM);
   assign SEL_BOOTROM     = tgt_stb_reg && (region_reg == REG_BOOTROM);
   assign SEL_FLASH       = tgt_stb_reg && (region_reg == REG_FLASH);

   // upper half reachable only in serial programming mode
   assign BOOTROM_ADDR = {bank_reg, addr_reg[BOOT_MAP_BITS-1:0]};

endmodule

// ---- data_area_map_properties.sv ----
// ****************************************************************
// bus timing and decode checks seen at the map's ports
// ****************************************************************
module data_area_map_properties (
   // clock and reset
   input wire logic        CLK,
   input wire logic        RST,
   // bus side
   input wire logic        CYC_I,
   input wire logic        STB_I,
   input wire logic        ACK_O,
   // code side and serial mode
   input wire logic [15:0] CODE_ADDR,
   input wire logic        CODE_BOOTROM_HIT,
   input wire logic        SERIAL_PROG_MODE,
   input wire logic        SERIAL_BANK_SEL,
   // target side
   input wire logic [15:0] TGT_ADDR,
   input wire logic        SEL_REGWIN_LOW,
   input wire logic        SEL_REGWIN_HIGH,
   input wire logic        SEL_REGWIN_MID,
   input wire logic        SEL_RAM,
   input wire logic        SEL_BOOTROM,
   input wire logic        SEL_FLASH,
   input wire logic [11:0] BOOTROM_ADDR
);
   default clocking @(posedge CLK); endclocking
   default disable iff (RST);
   // request taken, then a single-cycle answer three edges later
   sequence s_take;
      CYC_I && $rose(STB_I);
   endsequence
   sequence s_answer;
      !ACK_O [*2] ##1 ACK_O ##1 !ACK_O;
   endsequence
   property p_answer; s_take |=> s_answer; endproperty
   property p_low; SEL_REGWIN_LOW |-> TGT_ADDR <= 16'h003f; endproperty
   property p_mid; SEL_REGWIN_MID |-> TGT_ADDR >= 16'h0e40 && TGT_ADDR <= 16'h0eff; endproperty
   property p_high;
      SEL_REGWIN_HIGH |-> TGT_ADDR[15:8] == 8'h0f && !(TGT_ADDR inside {[16'h0fd0:16'h0fd2]});
   endproperty
   property p_ram; SEL_RAM |-> (TGT_ADDR inside {[16'h0040:16'h083f]}) ##2 ACK_O; endproperty
   property p_flash; SEL_FLASH |-> TGT_ADDR[15]; endproperty
   property p_boot;
      SEL_BOOTROM |-> TGT_ADDR inside {[16'h1000:16'h17ff]} && BOOTROM_ADDR[10:0] == TGT_ADDR[10:0];
   endproperty
   property p_bank;
      SEL_BOOTROM |-> BOOTROM_ADDR[11] == ($past(SERIAL_PROG_MODE) && $past(SERIAL_BANK_SEL));
   endproperty
   property p_code; CODE_BOOTROM_HIT |-> CODE_ADDR inside {[16'h1000:16'h17ff]}; endproperty
   property p_reset_unmapped; $fell(RST) |-> !CODE_BOOTROM_HIT; endproperty
   property p_onehot;
      $onehot0({SEL_REGWIN_LOW, SEL_REGWIN_HIGH, SEL_REGWIN_MID, SEL_RAM, SEL_BOOTROM, SEL_FLASH});
   endproperty
   a_answer: assert property (p_answer) else $error("answer timing wrong");
   a_low: assert property (p_low) else $error("low window select out of range");
   a_mid: assert property (p_mid) else $error("mid window select out of range");
   a_high: assert property (p_high) else $error("high window select out of range");
   a_ram: assert property (p_ram) else $error("ram select wrong");
   a_flash: assert property (p_flash) else $error("flash select out of range");
   a_boot: assert property (p_boot) else $error("boot rom select wrong");
   a_bank: assert property (p_bank) else $error("boot rom bank wrong");
   a_code: assert property (p_code) else $error("code hit out of range");
   a_reset_unmapped: assert property (p_reset_unmapped) else $error("mapped after reset");
   a_onehot: assert property (p_onehot) else $error("several selects");
endmodule
bind data_area_map data_area_map_properties u_props (.CLK(CLK), .RST(RST), .CYC_I(CYC_I),
   .STB_I(STB_I), .ACK_O(ACK_O), .CODE_ADDR(CODE_ADDR), .CODE_BOOTROM_HIT(CODE_BOOTROM_HIT),
   .SERIAL_PROG_MODE(SERIAL_PROG_MODE), .SERIAL_BANK_SEL(SERIAL_BANK_SEL), .TGT_ADDR(TGT_ADDR),
   .SEL_REGWIN_LOW(SEL_REGWIN_LOW), .SEL_REGWIN_HIGH(SEL_REGWIN_HIGH),
   .SEL_REGWIN_MID(SEL_REGWIN_MID), .SEL_RAM(SEL_RAM), .SEL_BOOTROM(SEL_BOOTROM),
   .SEL_FLASH(SEL_FLASH), .BOOTROM_ADDR(BOOTROM_ADDR));

// ---- data_area_targets.sv ----
// ****************************************************************
// memory and register targets behind the map
// ****************************************************************
module data_area_targets (
   // clock
   input  wire logic        clk,
   // requests
   input  wire logic [15:0] tgt_addr,
   input  wire logic [11:0] boot_addr,
   input  wire logic        sel_regwin,
   input  wire logic        sel_ram,
   input  wire logic        sel_boot,
   input  wire logic        sel_flash,
   // answers
   output logic      [7:0]  rd_regwin,
   output logic      [7:0]  rd_ram,
   output logic      [7:0]  rd_boot,
   output logic      [7:0]  rd_flash
);
   timeunit 1ns;
   timeprecision 1ps;
   // address-derived contents, nothing stored
   function automatic logic [7:0] pat(input logic [15:0] a, input logic [7:0] s);
      return a[7:0] ^ a[15:8] ^ s;
   endfunction
   initial begin
      {rd_regwin, rd_ram, rd_boot, rd_flash} = 32'h0;
   end
   // answer one cycle after a select, otherwise keep toggling so stale data shows
   always @(posedge clk) begin
      rd_regwin <= sel_regwin ? pat(tgt_addr, 8'h3c) : ~rd_regwin;
      rd_ram <= sel_ram ? pat(tgt_addr, 8'h5a) : ~rd_ram;
      rd_boot <= sel_boot ? pat({4'h0, boot_addr}, 8'ha5) : ~rd_boot;
      rd_flash <= sel_flash ? pat(tgt_addr, 8'hc3) : ~rd_flash;
   end
endmodule

// ---- data_area_map_tb.sv ----
// ****************************************************************
// self-checking bench of the data-area map
// ****************************************************************
module data_area_map_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import data_area_pkg::*;
   logic        clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, sel = 1'b1;
   logic        spm = 1'b0, bank = 1'b0, ack, code_hit, tgt_we;
   logic [15:0] adr = 16'h0, code_addr = 16'h0, tgt_addr;
   logic [7:0]  dat = 8'h0, dat_o, tgt_wdata, rd_regwin, rd_ram, rd_boot, rd_flash;
   logic        s_low, s_high, s_mid, s_ram, s_boot, s_flash;
   logic [11:0] boot_addr;
   logic [7:0]  staging = 8'h40, active = 8'h40;     // bench copy of the mapping registers
   int          bad_count = 0, samples_checked = 0, cycles = 0;
   logic [15:0] edges[$] = '{16'h0000, 16'h003f, 16'h0040, 16'h083f, 16'h0840, 16'h0e3f,
      16'h0e40, 16'h0eff, 16'h0f00, 16'h0fcf, 16'h0fff, 16'h17ff, 16'h7fff, 16'h8000, 16'hffff};
   always #2 clk = ~clk;
   data_area_map DUT (.CLK(clk), .RST(rst), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr),
      .DAT_I(dat), .SEL_I(sel), .DAT_O(dat_o), .ACK_O(ack), .CODE_ADDR(code_addr),
      .CODE_BOOTROM_HIT(code_hit), .SERIAL_PROG_MODE(spm), .SERIAL_BANK_SEL(bank),
      .TGT_ADDR(tgt_addr), .TGT_WDATA(tgt_wdata), .TGT_WE(tgt_we), .SEL_REGWIN_LOW(s_low),
      .SEL_REGWIN_HIGH(s_high), .SEL_REGWIN_MID(s_mid), .SEL_RAM(s_ram), .SEL_BOOTROM(s_boot),
      .SEL_FLASH(s_flash), .BOOTROM_ADDR(boot_addr), .RDATA_REGWIN(rd_regwin),
      .RDATA_RAM(rd_ram), .RDATA_BOOTROM(rd_boot), .RDATA_FLASH(rd_flash));
   data_area_targets u_targets (.clk(clk), .tgt_addr(tgt_addr), .boot_addr(boot_addr),
      .sel_regwin(s_low | s_high | s_mid), .sel_ram(s_ram), .sel_boot(s_boot),
      .sel_flash(s_flash), .rd_regwin(rd_regwin), .rd_ram(rd_ram), .rd_boot(rd_boot),
      .rd_flash(rd_flash));
   // ****************************************************************
   // model and helpers
   // ****************************************************************
   function automatic logic [7:0] pat(input logic [15:0] a, input logic [7:0] s);
      return a[7:0] ^ a[15:8] ^ s;
   endfunction
   function automatic logic [7:0] model_read(input logic [15:0] a);
      if (a == 16'h0fd0) return staging;
      if (a == 16'h0fd1) return 8'h00;
      if (a == 16'h0fd2) return active;
      if (a <= 16'h003f || (a >= 16'h0e40 && a <= 16'h0fff)) return pat(a, 8'h3c);
      if (a >= 16'h0040 && a <= 16'h083f) return pat(a, 8'h5a);
      if (a >= 16'h1000 && a <= 16'h17ff)
         return active[4] ? pat({4'h0, spm & bank, a[10:0]}, 8'ha5) : 8'hff;
      if (a[15]) return pat(a, 8'hc3);
      return 8'hff;
   endfunction
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // one classic wishbone cycle, answer compared with the model
   task automatic access(input logic w, input logic [15:0] a, input logic [7:0] d);
      logic [7:0] exp;
      @(posedge clk);
      exp = w ? 8'h00 : model_read(a);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      // wait for the answer however long it takes, only the hang guard ends it
      do begin
         @(posedge clk);
      end while (ack !== 1'b1);
      check("bus data", dat_o, exp);
      cyc <= 1'b0;
      stb <= 1'b0;
      if (w && a == 16'h0fd0) staging = d;
      if (w && a == 16'h0fd1 && d == 8'hd5) active = staging;
   endtask
   task automatic code_chk(input logic [15:0] a);
      @(posedge clk);
      code_addr <= a;
      #1;
      check("code hit", {7'h0, code_hit}, {7'h0, active[4] && a inside {[16'h1000:16'h17ff]}});
   endtask
   task automatic report_and_stop();
      if (bad_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // forwarded write data must be what the master holds on the bus
   always @(posedge clk) begin
      if (tgt_we) check("target wdata", tgt_wdata, dat);
   end
   // hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == 6000) begin
         bad_count++;
         report_and_stop();
      end
   end
   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial begin
      logic [15:0] a;
      logic [7:0]  d;
      void'($urandom(32'h8bdd76e1));
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      code_chk(16'h1000);
      access(1'b0, 16'h0fd2, 8'h00);
      access(1'b0, 16'h1000, 8'h00);
      foreach (edges[i]) access(1'b0, edges[i], 8'h00);
      access(1'b1, 16'h0fd0, 8'h50);
      access(1'b0, 16'h0fd0, 8'h00);
      code_chk(16'h1000);
      access(1'b0, 16'h0fd2, 8'h00);
      access(1'b0, 16'h1000, 8'h00);
      access(1'b1, 16'h0fd1, 8'hd5);
      code_chk(16'h17ff);
      code_chk(16'h1800);
      for (int m = 0; m < 4; m++) begin
         spm <= m[1];
         bank <= m[0];
         access(1'b0, 16'h17ff, 8'h00);
      end
      access(1'b1, 16'h0fd2, 8'h00);
      access(1'b0, 16'h0fd2, 8'h00);
      repeat (180) begin
         a = 16'($urandom) & (($urandom % 2) ? 16'h1fff : 16'hffff);
         d = (a == 16'h0fd1) ? 8'hd5 : 8'($urandom);
         spm <= 1'($urandom);
         bank <= 1'($urandom);
         code_chk(16'($urandom) & 16'h1fff);
         access(1'($urandom), a, d);
      end
      // reset in mid-run returns both mapping registers to their reset value
      @(posedge clk);
      rst <= 1'b1;
      @(posedge clk);
      rst <= 1'b0;
      staging = FLASH_MAP_RESET;
      active = FLASH_MAP_RESET;
      code_chk(16'h1000);
      access(1'b0, 16'h0fd0, 8'h00);
      access(1'b0, 16'h0fd2, 8'h00);
      report_and_stop();
   end
endmodule
